// ---- rtl/cce_defines.vh ----
// Register offsets, field positions, reset values and timing counts for the control channel error block
`ifndef CCE_DEFINES_VH
`define CCE_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CCE_OFS_FAULT_CTL    8'h46
`define CCE_OFS_FAULT_STATUS 8'h47
`define CCE_OFS_SPARE_48     8'h48
`define CCE_OFS_PAGE_SELECT  8'h4c

// ----------------------------------------------------------------
// Fault control fields and reset value
// ----------------------------------------------------------------
`define CCE_CTL_EARLY_ACK    7
`define CCE_CTL_DATA_CHK     6
`define CCE_CTL_ENH_CHK      5
`define CCE_CTL_FTYPE_HI     4
`define CCE_CTL_FTYPE_LO     3
`define CCE_CTL_FBYTE_HI     2
`define CCE_CTL_FBYTE_LO     0
`define CCE_CTL_RESET        8'h20

// ----------------------------------------------------------------
// Fault types
// ----------------------------------------------------------------
`define CCE_FT_NONE          2'h0
`define CCE_FT_CRC_SEL       2'h1
`define CCE_FT_CRC_NEXT      2'h2
`define CCE_FT_DATA_SEL      2'h3

// ----------------------------------------------------------------
// Status fields
// ----------------------------------------------------------------
`define CCE_ST_SEQ           5
`define CCE_ST_INIT_ERR      4
`define CCE_ST_INIT_TO       3
`define CCE_ST_TGT_ERR       2
`define CCE_ST_TGT_TO        1
`define CCE_ST_ECHO          0

// ----------------------------------------------------------------
// Page select fields and reset value
// ----------------------------------------------------------------
`define CCE_PS_READ_HI       5
`define CCE_PS_READ_LO       4
`define CCE_PS_RESET         8'h00

// ----------------------------------------------------------------
// Watchdog
// ----------------------------------------------------------------
`define CCE_WDOG_CYCLES      1000

`endif

// ---- rtl/cce_port_regs.v ----
// One receive port's copy of the control channel error control and status registers
`timescale 1ns/1ps
`include "cce_defines.vh"

module cce_port_regs #(
    parameter WDOG_CYCLES = `CCE_WDOG_CYCLES
) (
    // Clock and reset
    input  wire       i_clk,
    input  wire       i_reset,
    // Register access already paged for this port
    input  wire       i_ctl_wr,
    input  wire [7:0] i_wdata,
    input  wire       i_status_rd,
    // Port link events
    input  wire       i_seq_err,
    input  wire       i_crc_err,
    input  wire       i_lock_err,
    input  wire       i_seq_status,
    input  wire       i_init_wait,
    input  wire       i_tgt_wait,
    input  wire       i_echo_valid,
    input  wire [7:0] i_echo_data,
    input  wire [7:0] i_sent_data,
    input  wire       i_remote_ack,
    input  wire       i_read_start,
    input  wire       i_fwd_byte,
    input  wire       i_fwd_first,
    // Register views
    output wire [7:0] o_ctl,
    output wire [7:0] o_status,
    // Channel effects
    output reg        o_early_ack,
    output reg        o_local_nack,
    output reg        o_abort,
    output reg        o_force_crc,
    output reg        o_force_data
);

    reg  [7:0]  ctl_r;
    reg  [5:0]  flags_r;
    reg  [1:0]  pend_type_r;
    reg         crc_next_r;
    reg  [3:0]  byte_cnt_r;
    reg  [31:0] wdog_r;
    wire        enh = ctl_r[`CCE_CTL_ENH_CHK];
    wire        link_err = i_seq_err | i_crc_err | i_lock_err;
    wire        waiting = i_init_wait | i_tgt_wait;
    wire        wdog_exp = waiting && (wdog_r == WDOG_CYCLES - 1);
    wire        mismatch = i_echo_valid && ctl_r[`CCE_CTL_DATA_CHK] && (i_echo_data != i_sent_data);
    wire [2:0]  cur_idx = i_fwd_first ? 3'h0 : byte_cnt_r[2:0];
    wire        sel_hit = i_fwd_byte && (i_fwd_first || byte_cnt_r < 4'h8)
                          && (cur_idx == ctl_r[`CCE_CTL_FBYTE_HI:`CCE_CTL_FBYTE_LO]);
    wire        seq_view;

    assign seq_view = enh ? flags_r[`CCE_ST_SEQ] : i_seq_status;
    assign o_ctl    = {ctl_r[7:5], pend_type_r, ctl_r[2:0]};
    assign o_status = {2'h0, seq_view, flags_r[4:0]};

    // ----------------------------------------------------------------
    // Control register and single-shot fault injection
    // ----------------------------------------------------------------
    // The fault type field reads back until the selected byte has been forwarded
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            ctl_r       <= `CCE_CTL_RESET;
            pend_type_r <= `CCE_FT_NONE;
            crc_next_r  <= 1'b0;
            byte_cnt_r  <= 4'h0;
            o_force_crc <= 1'b0;
            o_force_data<= 1'b0;
        end else begin
            o_force_crc  <= 1'b0;
            o_force_data <= 1'b0;
            if (i_fwd_byte) begin
                byte_cnt_r <= i_fwd_first ? 4'h1 : (byte_cnt_r == 4'hf ? 4'hf : byte_cnt_r + 4'h1);
            end
            if (crc_next_r && i_fwd_byte && !sel_hit) begin
                o_force_crc <= 1'b1;
                crc_next_r  <= 1'b0;
            end
            if (sel_hit && pend_type_r != `CCE_FT_NONE) begin
                case (pend_type_r)
                    `CCE_FT_CRC_SEL:  o_force_crc  <= 1'b1;
                    `CCE_FT_CRC_NEXT: crc_next_r   <= 1'b1;
                    `CCE_FT_DATA_SEL: o_force_data <= 1'b1;
                    default:          o_force_crc  <= 1'b0;
                endcase
                pend_type_r <= `CCE_FT_NONE;
            end
            if (i_ctl_wr) begin
                ctl_r       <= i_wdata;
                pend_type_r <= i_wdata[`CCE_CTL_FTYPE_HI:`CCE_CTL_FTYPE_LO];
            end
        end
    end

    // ----------------------------------------------------------------
    // Watchdog
    // ----------------------------------------------------------------
    // count while waiting, restart when idle or expired
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            wdog_r <= 32'h0;
        end else if (!waiting || wdog_exp) begin
            wdog_r <= 32'h0;
        end else begin
            wdog_r <= wdog_r + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // Sticky status flags; set beats clear-on-read
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            flags_r <= 6'h00;
        end else begin
            if (i_status_rd) begin
                flags_r <= 6'h00;
            end
            if (enh && i_seq_err) flags_r[`CCE_ST_SEQ] <= 1'b1;
            if (enh && i_init_wait && link_err) flags_r[`CCE_ST_INIT_ERR] <= 1'b1;
            if (enh && i_init_wait && wdog_exp) flags_r[`CCE_ST_INIT_TO] <= 1'b1;
            if (enh && i_tgt_wait && link_err) flags_r[`CCE_ST_TGT_ERR] <= 1'b1;
            if (i_tgt_wait && wdog_exp) flags_r[`CCE_ST_TGT_TO] <= 1'b1;
            if (enh && mismatch) flags_r[`CCE_ST_ECHO] <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Channel responses
    // ----------------------------------------------------------------
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_early_ack  <= 1'b0;
            o_local_nack <= 1'b0;
            o_abort      <= 1'b0;
        end else begin
            o_early_ack  <= ctl_r[`CCE_CTL_EARLY_ACK] && i_read_start;
            o_local_nack <= i_echo_valid && (!i_remote_ack || mismatch);
            o_abort      <= enh && ((waiting && (link_err || wdog_exp)) || mismatch);
        end
    end

endmodule

// ---- rtl/cce_error_regs.v ----
// Paged control channel error registers for four receive ports
//
// Behaviour
// - Reads use page select bits 5:4; writes go to every enabled port.
// - Each port keeps its own control and status registers.
// - Early-ack bit makes internal acknowledge at remote target read start.
// - Data check turns remote ack into local nack on echo mismatch.
// - Enhanced checking, default on, aborts transactions on channel errors.
// - Fault type: none, CRC on byte, CRC on the following forward byte, data error.
// - Each non-zero fault write injects exactly one fault.
// - Byte index 0 to 7 picks the forward byte to corrupt.
// - Sequence flag mirrors port status unless enhanced, then clears on read.
// - Initiator link fault flag when error while awaiting response.
// - Initiator timeout flag when watchdog expires awaiting response.
// - Target link fault flag when error while awaiting response.
// - Target timeout flag on watchdog expiry; clears on read.
// - Serializer echoes data; mismatch sets echo flag, clears on read.
`timescale 1ns/1ps
`include "cce_defines.vh"

module cce_error_regs #(
    parameter NPORTS      = 4,
    parameter WDOG_CYCLES = `CCE_WDOG_CYCLES
) (
    // Clock and reset
    input  wire                i_clk,
    input  wire                i_reset,
    // Local register port
    input  wire                i_reg_wr,
    input  wire                i_reg_rd,
    input  wire [7:0]          i_reg_addr,
    input  wire [7:0]          i_reg_wdata,
    output reg  [7:0]          o_reg_rdata,
    // Per-port link events, one bit or byte per port
    input  wire [NPORTS-1:0]   i_seq_err,
    input  wire [NPORTS-1:0]   i_crc_err,
    input  wire [NPORTS-1:0]   i_lock_err,
    input  wire [NPORTS-1:0]   i_seq_status,
    input  wire [NPORTS-1:0]   i_init_wait,
    input  wire [NPORTS-1:0]   i_tgt_wait,
    input  wire [NPORTS-1:0]   i_echo_valid,
    input  wire [8*NPORTS-1:0] i_echo_data,
    input  wire [8*NPORTS-1:0] i_sent_data,
    input  wire [NPORTS-1:0]   i_remote_ack,
    input  wire [NPORTS-1:0]   i_read_start,
    input  wire [NPORTS-1:0]   i_fwd_byte,
    input  wire [NPORTS-1:0]   i_fwd_first,
    // Per-port channel effects
    output wire [NPORTS-1:0]   o_early_ack,
    output wire [NPORTS-1:0]   o_local_nack,
    output wire [NPORTS-1:0]   o_abort,
    output wire [NPORTS-1:0]   o_force_crc,
    output wire [NPORTS-1:0]   o_force_data
);

    reg  [7:0]          page_r;
    wire [1:0]          rd_port = page_r[`CCE_PS_READ_HI:`CCE_PS_READ_LO];
    wire [8*NPORTS-1:0] ctl_all;
    wire [8*NPORTS-1:0] sts_all;

    // ----------------------------------------------------------------
    // Page select register
    // ----------------------------------------------------------------
    // Top two bits read as zero from the local interface
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            page_r <= `CCE_PS_RESET;
        end else if (i_reg_wr && i_reg_addr == `CCE_OFS_PAGE_SELECT) begin
            page_r <= {2'h0, i_reg_wdata[5:0]};
        end
    end

    // ----------------------------------------------------------------
    // Per-port register copies
    // ----------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < NPORTS; p = p + 1) begin : g_port
            wire ctl_wr;
            wire st_rd;
            assign ctl_wr = i_reg_wr && (i_reg_addr == `CCE_OFS_FAULT_CTL) && page_r[p];
            // Only the paged port sees its status read, so other ports keep flags
            assign st_rd  = i_reg_rd && (i_reg_addr == `CCE_OFS_FAULT_STATUS) && (rd_port == p);
            cce_port_regs #(
                .WDOG_CYCLES (WDOG_CYCLES)
            ) u_port (
                .i_clk        (i_clk),
                .i_reset      (i_reset),
                .i_ctl_wr     (ctl_wr),
                .i_wdata      (i_reg_wdata),
                .i_status_rd  (st_rd),
                .i_seq_err    (i_seq_err[p]),
                .i_crc_err    (i_crc_err[p]),
                .i_lock_err   (i_lock_err[p]),
                .i_seq_status (i_seq_status[p]),
                .i_init_wait  (i_init_wait[p]),
                .i_tgt_wait   (i_tgt_wait[p]),
                .i_echo_valid (i_echo_valid[p]),
                .i_echo_data  (i_echo_data[8*p+7:8*p]),
                .i_sent_data  (i_sent_data[8*p+7:8*p]),
                .i_remote_ack (i_remote_ack[p]),
                .i_read_start (i_read_start[p]),
                .i_fwd_byte   (i_fwd_byte[p]),
                .i_fwd_first  (i_fwd_first[p]),
                .o_ctl        (ctl_all[8*p+7:8*p]),
                .o_status     (sts_all[8*p+7:8*p]),
                .o_early_ack  (o_early_ack[p]),
                .o_local_nack (o_local_nack[p]),
                .o_abort      (o_abort[p]),
                .o_force_crc  (o_force_crc[p]),
                .o_force_data (o_force_data[p])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Read data, registered
    // ----------------------------------------------------------------
    // read page mux
    always @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
            o_reg_rdata <= 8'h00;
        end else if (i_reg_rd) begin
            case (i_reg_addr)
                `CCE_OFS_FAULT_CTL:    o_reg_rdata <= ctl_all[8*rd_port +: 8];
                `CCE_OFS_FAULT_STATUS: o_reg_rdata <= sts_all[8*rd_port +: 8];
                `CCE_OFS_PAGE_SELECT:  o_reg_rdata <= page_r;
                default:               o_reg_rdata <= 8'h00;
            endcase
        end
    end

endmodule

// ---- test/cce_error_regs_monitor.sv ----
// Assertion checker bound to the paged control channel error register block
`timescale 1ns/1ps

module cce_error_regs_mon #(
    parameter NPORTS      = 4,
    parameter WDOG_CYCLES = 1000
) (
    // Clock and reset
    input logic              i_clk,
    input logic              i_reset,
    // Register port
    input logic              i_reg_rd,
    input logic [7:0]        i_reg_addr,
    input logic [7:0]        o_reg_rdata,
    // Link events
    input logic [NPORTS-1:0] i_seq_err,
    input logic [NPORTS-1:0] i_crc_err,
    input logic [NPORTS-1:0] i_lock_err,
    input logic [NPORTS-1:0] i_init_wait,
    input logic [NPORTS-1:0] i_tgt_wait,
    input logic [NPORTS-1:0] i_echo_valid,
    input logic [NPORTS-1:0] i_read_start,
    input logic [NPORTS-1:0] i_fwd_byte,
    // Channel effects
    input logic [NPORTS-1:0] o_early_ack,
    input logic [NPORTS-1:0] o_local_nack,
    input logic [NPORTS-1:0] o_abort,
    input logic [NPORTS-1:0] o_force_crc,
    input logic [NPORTS-1:0] o_force_data
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);

    // Anything that may justify an abort one cycle later
    wire [NPORTS-1:0] cause = i_seq_err | i_crc_err | i_lock_err | i_echo_valid | i_init_wait | i_tgt_wait;

    AST_EARLY_ACK: assert property ((o_early_ack & ~$past(i_read_start)) == '0)
        else $error("Early ack without a read start");
    AST_LOCAL_NACK: assert property ((o_local_nack & ~$past(i_echo_valid)) == '0)
        else $error("Local nack without an echo");
    AST_ABORT_CAUSE: assert property ((o_abort & ~$past(cause)) == '0)
        else $error("Abort without a channel fault");
    AST_FORCE_BYTE: assert property (((o_force_crc | o_force_data) & ~$past(i_fwd_byte)) == '0)
        else $error("Forced fault not tied to a forward byte");
    AST_FORCE_ONCE: assert property (((o_force_crc & $past(o_force_crc)) | (o_force_data & $past(o_force_data))) == '0)
        else $error("Forced fault longer than one cycle");
    AST_RDATA_HOLD: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
        else $error("Read data moved without a read");
    AST_SPARE_ZERO: assert property ($past(i_reg_rd) && $past(i_reg_addr) == 8'h48 |-> o_reg_rdata == 8'h00)
        else $error("Spare register read non-zero");
    AST_TOP_BITS: assert property ($past(i_reg_rd) && ($past(i_reg_addr) == 8'h47 || $past(i_reg_addr) == 8'h4c)
        |-> o_reg_rdata[7:6] == 2'h0)
        else $error("Reserved status or page bits read non-zero");

    COV_EARLY: cover property (o_early_ack != '0);
    COV_FORCE: cover property (o_force_crc != '0);
    COV_ABORT: cover property (o_abort != '0);
endmodule

bind cce_error_regs cce_error_regs_mon #(.NPORTS(NPORTS), .WDOG_CYCLES(WDOG_CYCLES)) u_mon (
    .i_clk(i_clk), .i_reset(i_reset), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
    .o_reg_rdata(o_reg_rdata), .i_seq_err(i_seq_err), .i_crc_err(i_crc_err), .i_lock_err(i_lock_err),
    .i_init_wait(i_init_wait), .i_tgt_wait(i_tgt_wait), .i_echo_valid(i_echo_valid),
    .i_read_start(i_read_start), .i_fwd_byte(i_fwd_byte), .o_early_ack(o_early_ack),
    .o_local_nack(o_local_nack), .o_abort(o_abort), .o_force_crc(o_force_crc), .o_force_data(o_force_data));

// ---- test/cce_ser_model.sv ----
// Behavioural remote serializer that echoes forward bytes back over the channel
`timescale 1ns/1ps

module cce_ser_model (
    // Clock
    input  wire        i_clk,
    // Echo requests from the bench, one bit or byte per port
    input  wire [3:0]  i_req,
    input  wire [3:0]  i_bad,
    input  wire [31:0] i_data,
    // Returned traffic
    output reg  [3:0]  o_echo_valid = 4'h0,
    output reg  [3:0]  o_ack = 4'h0,
    output reg  [31:0] o_echo_data = 32'h0
);
    integer p;
    // echo sent data
    // Idle lanes toggle so a stale byte can never pass for a real echo
    always @(posedge i_clk) begin
        o_echo_valid <= i_req;
        o_ack <= i_req | ~o_ack;
        for (p = 0; p < 4; p = p + 1)
            o_echo_data[8*p +: 8] <= !i_req[p] ? ~o_echo_data[8*p +: 8] :
                                     i_bad[p] ? ~i_data[8*p +: 8] : i_data[8*p +: 8];
    end
endmodule

// ---- test/test_cce_error_regs.sv ----
// Self-checking bench for the paged control channel error registers
`timescale 1ns/1ps

module test_cce_error_regs;
    localparam WD = 8; // Short watchdog keeps the run brief
    reg         i_clk = 1'b0;
    reg         i_reset = 1'b1;
    reg         i_reg_wr = 1'b0;
    reg         i_reg_rd = 1'b0;
    reg  [7:0]  i_reg_addr = 8'h00;
    reg  [7:0]  i_reg_wdata = 8'h00;
    reg  [3:0]  i_seq_err = 4'h0, i_crc_err = 4'h0, i_lock_err = 4'h0, i_seq_status = 4'h0;
    reg  [3:0]  i_init_wait = 4'h0, i_tgt_wait = 4'h0, i_read_start = 4'h0;
    reg  [3:0]  i_fwd_byte = 4'h0, i_fwd_first = 4'h0, req = 4'h0, bad = 4'h0;
    reg  [31:0] i_sent_data = 32'h0;
    wire [3:0]  i_echo_valid, i_remote_ack, o_early_ack, o_local_nack, o_abort, o_force_crc, o_force_data;
    wire [31:0] i_echo_data;
    wire [7:0]  o_reg_rdata;
    integer     error_cnt = 0, checked = 0, p, t, j;

    always #4 i_clk = ~i_clk;

    cce_error_regs #(.NPORTS(4), .WDOG_CYCLES(WD)) i_dut (
        .i_clk        (i_clk),
        .i_reset      (i_reset),
        .i_reg_wr     (i_reg_wr),
        .i_reg_rd     (i_reg_rd),
        .i_reg_addr   (i_reg_addr),
        .i_reg_wdata  (i_reg_wdata),
        .o_reg_rdata  (o_reg_rdata),
        .i_seq_err    (i_seq_err),
        .i_crc_err    (i_crc_err),
        .i_lock_err   (i_lock_err),
        .i_seq_status (i_seq_status),
        .i_init_wait  (i_init_wait),
        .i_tgt_wait   (i_tgt_wait),
        .i_echo_valid (i_echo_valid),
        .i_echo_data  (i_echo_data),
        .i_sent_data  (i_sent_data),
        .i_remote_ack (i_remote_ack),
        .i_read_start (i_read_start),
        .i_fwd_byte   (i_fwd_byte),
        .i_fwd_first  (i_fwd_first),
        .o_early_ack  (o_early_ack),
        .o_local_nack (o_local_nack),
        .o_abort      (o_abort),
        .o_force_crc  (o_force_crc),
        .o_force_data (o_force_data)
    );
    cce_ser_model i_ser (.i_clk(i_clk), .i_req(req), .i_bad(bad), .i_data(i_sent_data),
                         .o_echo_valid(i_echo_valid), .o_ack(i_remote_ack), .o_echo_data(i_echo_data));

    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task chk(input string n, input [31:0] s, input [31:0] e);
        checked = checked + 1;
        if (s !== e) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask
    task wr(input [7:0] a, input [7:0] v);
        @(negedge i_clk);
        i_reg_wr = 1'b1;
        i_reg_addr = a;
        i_reg_wdata = v;
        @(negedge i_clk);
        i_reg_wr = 1'b0;
    endtask
    task cr(input string n, input [7:0] a, input [7:0] e);
        @(negedge i_clk);
        i_reg_rd = 1'b1;
        i_reg_addr = a;
        @(negedge i_clk);
        i_reg_rd = 1'b0;
        chk(n, o_reg_rdata, e);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_reset;
        cr("ctl", 8'h46, 8'h20);
        cr("status", 8'h47, 8'h00);
        cr("spare", 8'h48, 8'h00);
        cr("page", 8'h4c, 8'h00);
    endtask
    task t_page;
        wr(8'h4c, 8'h0f);
        wr(8'h46, 8'h27);
        wr(8'h48, 8'hff);
        wr(8'h4c, 8'h04);
        wr(8'h46, 8'h41);
        for (p = 0; p < 4; p = p + 1) begin
            wr(8'h4c, {2'h0, p[1:0], 4'h0});
            cr("paged ctl", 8'h46, (p == 2) ? 8'h41 : 8'h27);
        end
        cr("spare", 8'h48, 8'h00);
    endtask
    task t_early;
        wr(8'h4c, 8'h0f);
        for (p = 0; p < 2; p = p + 1) begin
            wr(8'h46, p ? 8'h20 : 8'ha0);
            i_read_start = 4'h2;
            @(negedge i_clk);
            i_read_start = 4'h0;
            chk("early ack", o_early_ack, p ? 4'h0 : 4'h2);
        end
    endtask
    task t_echo;
        for (p = 0; p < 2; p = p + 1) begin
            wr(8'h4c, 8'h0f);
            wr(8'h46, p ? 8'h00 : 8'h60);
            i_sent_data = 32'h44332211;
            req = 4'h5;
            bad = 4'h4;
            @(negedge i_clk);
            req = 4'h0;
            bad = 4'h0;
            @(negedge i_clk);
            chk("local nack", o_local_nack, p ? 4'h0 : 4'h4);
            chk("abort", o_abort, p ? 4'h0 : 4'h4);
            wr(8'h4c, 8'h20);
            cr("echo flag", 8'h47, p ? 8'h00 : 8'h01);
            cr("echo cleared", 8'h47, 8'h00);
        end
    endtask
    task t_inject;
        wr(8'h4c, 8'h01);
        for (t = 0; t < 4; t = t + 1) begin
            wr(8'h46, {3'h1, t[1:0], 3'h2});
            cr("armed", 8'h46, {3'h1, t[1:0], 3'h2});
            for (j = 0; j < 8; j = j + 1) begin
                @(negedge i_clk);
                chk("force crc", o_force_crc, {3'h0, (j == 3 && t == 1) || (j == 4 && t == 2)});
                chk("force data", o_force_data, {3'h0, j == 3 && t == 3});
                i_fwd_byte = {3'h0, j < 7};
                i_fwd_first = {3'h0, j == 0 || j == 4};
            end
            cr("fired", 8'h46, 8'h22);
        end
    endtask
    task t_flags;
        wr(8'h46, 8'h20);
        i_init_wait = 4'h1;
        i_crc_err = 4'h1;
        @(negedge i_clk);
        chk("abort", o_abort, 4'h1);
        i_crc_err = 4'h0;
        i_init_wait = 4'h0;
        i_tgt_wait = 4'h1;
        i_lock_err = 4'h1;
        @(negedge i_clk);
        i_lock_err = 4'h0;
        i_tgt_wait = 4'h0;
        i_seq_err = 4'h1;
        @(negedge i_clk);
        i_seq_err = 4'h0;
        cr("link flags", 8'h47, 8'h34);
        cr("flags cleared", 8'h47, 8'h00);
        wr(8'h46, 8'h00);
        i_seq_status = 4'h1;
        i_init_wait = 4'h1;
        i_crc_err = 4'h1;
        @(negedge i_clk);
        chk("no abort", o_abort, 4'h0);
        i_crc_err = 4'h0;
        i_init_wait = 4'h0;
        cr("mirrored seq", 8'h47, 8'h20);
        i_seq_status = 4'h0;
        cr("seq follows", 8'h47, 8'h00);
    endtask
    task t_timeout;
        for (p = 0; p < 2; p = p + 1) begin
            wr(8'h46, p ? 8'h20 : 8'h00);
            i_tgt_wait = {3'h0, p == 0};
            i_init_wait = 4'h1;
            repeat (WD + 2) @(negedge i_clk);
            i_tgt_wait = 4'h0;
            i_init_wait = 4'h0;
            cr("timeout", 8'h47, p ? 8'h08 : 8'h02);
            cr("timeout cleared", 8'h47, 8'h00);
        end
    endtask

    task summarize;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence after a three-cycle reset
    initial begin
        repeat (3) @(negedge i_clk);
        i_reset = 1'b0;
        t_reset;
        t_page;
        t_early;
        t_echo;
        t_inject;
        t_flags;
        t_timeout;
        summarize;
    end
    // Watchdog well beyond the fewer than two hundred cycles the tests need
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        summarize;
    end
endmodule
